// >>> dv/test_usb_compound_power_ident.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_usb_compound_power_ident;
   logic core_clk, resetn, otp_valid, otp_lowpwr_active_high, otp_vid_en, otp_hub_self_powered;
   logic otp_serial_en, usb_suspended, usb_configured, usb_high_speed, board_self_powered;
   logic acm_driver_active, sel_gpio_seven, sel_modem_two_three, uart_tx, uart_rts_n;
   logic rs485_tx_en, uart_dtr_n, i2c_scl_drive_low, i2c_sda_drive_low, loaded;
   logic low_power_indicator, desc_ready, desc_self_powered, desc_func_high_speed;
   logic eth_phy_power_down, enhanced_io_seven_transmit_o, enhanced_io_seven_transmit_oe;
   logic enhanced_io_five_request_send_o, enhanced_io_five_request_send_oe;
   logic enhanced_io_four_clear_send_oe, enhanced_io_two_set_ready_oe;
   logic enhanced_io_three_terminal_ready_o, enhanced_io_three_terminal_ready_oe;
   logic cts_to_uart_en, dsr_to_uart_en, scl_o, scl_oe, sda_o, sda_oe;
   logic l_lp, l_ven, l_hsp, l_sen, e_lp, e_pd, e_sp, e_hs;
   logic [15:0] otp_vid, desc_vid, desc_pid, l_vid, e_vid, e_pid;
   logic [4:0] otp_pid_en, desc_endpoints, l_pen, e_ep;
   logic [79:0] otp_pid, l_pid;
   logic [7:0] otp_serial_char, gpio_out, gpio_oe, desc_serial_char, desc_max_power;
   logic [7:0] l_sch, e_ser, e_mp;
   logic [47:0] mac_addr, l_mac;
   logic [2:0] desc_func, host_cmd;
   logic [3:0] desc_serial_idx, nib;
   logic [1:0] sel_mode_five, desc_num_config, e_p7, e_p5, e_p3, e_i2c;
   wire scl_line, sda_line;
   logic [3:0] e_fl;
   wire [3:0] flow_seen = {cts_to_uart_en, enhanced_io_four_clear_send_oe, dsr_to_uart_en,
      enhanced_io_two_set_ready_oe};
   logic [15:0] pid_def [5] = '{ucp_pkg::PID_HUB_DEFAULT, ucp_pkg::PID_ETH_DEFAULT,
      ucp_pkg::PID_UART_DEFAULT, ucp_pkg::PID_I2C_DEFAULT, ucp_pkg::PID_GPIO_DEFAULT};
   int num_errors = 0;
   int check_count = 0;
   int ef, n, rnd;

   ucp_top i_dut (.*);
   ucp_host_model i_host (.*);

   // ------------------------------------------------------------
   // Clock, watchdog, verdict
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      #(50 * 4000);
      num_errors++;
      summarize();
   end

   task automatic summarize();
      if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   // ------------------------------------------------------------
   // Stimulus and reference model
   // ------------------------------------------------------------
   task automatic drive_rand();
      host_cmd <= 3'($urandom());
      {board_self_powered, desc_func, desc_serial_idx} <= 8'($urandom());
      {acm_driver_active, sel_gpio_seven, sel_modem_two_three, uart_tx} <= 4'($urandom());
      {uart_rts_n, rs485_tx_en, uart_dtr_n, i2c_scl_drive_low} <= 4'($urandom());
      {i2c_sda_drive_low, sel_mode_five, gpio_out, gpio_oe} <= 19'($urandom());
      otp_valid <= 1'($urandom());
      {otp_lowpwr_active_high, otp_vid_en, otp_hub_self_powered, otp_serial_en} <=
         loaded ? 4'($urandom()) : {l_lp, l_ven, l_hsp, l_sen};
      otp_vid <= loaded ? 16'($urandom()) : l_vid;
      otp_pid_en <= loaded ? ~l_pen : l_pen;
      otp_pid <= loaded ? ~l_pid : l_pid;
      otp_serial_char <= loaded ? ~l_sch : l_sch;
      mac_addr <= loaded ? ~l_mac : l_mac;
   endtask : drive_rand

   task automatic step(input bit chk);
      if (chk) begin
         `CHK("indicator", e_lp, low_power_indicator)
         `CHK("phy_down", e_pd, eth_phy_power_down)
         `CHK("vid", e_vid, desc_vid)
         `CHK("pid", e_pid, desc_pid)
         if (ef < 5) begin
            `CHK("serial", e_ser, desc_serial_char)
            `CHK("endpoints", e_ep, desc_endpoints)
            `CHK("configs", 2'h1, desc_num_config)
            `CHK("power", {e_sp, e_mp}, {desc_self_powered, desc_max_power})
            `CHK("speed", e_hs, desc_func_high_speed)
         end
         `CHK("pin7", e_p7, {enhanced_io_seven_transmit_o, enhanced_io_seven_transmit_oe})
         `CHK("pin5", e_p5, {enhanced_io_five_request_send_o, enhanced_io_five_request_send_oe})
         `CHK("pin3", e_p3, {enhanced_io_three_terminal_ready_o,
            enhanced_io_three_terminal_ready_oe})
         `CHK("i2c", e_i2c, {scl_line, sda_line})
         `CHK("flow", e_fl, flow_seen)
         `CHK("ready_hold", 1'b1, desc_ready)
      end
      ef = int'(desc_func);
      n = int'(desc_serial_idx);
      e_lp = (usb_suspended || !usb_configured) ~^ l_lp;
      e_pd = usb_suspended && !(l_hsp && board_self_powered);
      e_vid = l_ven ? l_vid : ucp_pkg::VID_DEFAULT;
      e_pid = 16'h0000;
      if (ef < 5) e_pid = l_pen[ef] ? l_pid[16*ef +: 16] : pid_def[ef];
      nib = (n < 12) ? l_mac[47 - 4*n -: 4] : 4'h0;
      e_ser = (n > 12) ? 8'h00 : (n == 12) ? (l_sen ? l_sch : 8'h30 + 8'(ef)) :
         (nib < 4'ha) ? 8'h30 + 8'(nib) : 8'h37 + 8'(nib);
      e_ep = (ef == 0) ? 5'h03 : (ef < 3) ? 5'h1b : 5'h07;
      e_sp = (ef == 0) ? l_hsp : 1'b1;
      e_mp = (ef == 0 && !l_hsp) ? 8'h7d : 8'h00;
      e_hs = (ef == 0) ? usb_high_speed : 1'b1;
      e_p7 = sel_gpio_seven ? {gpio_out[7], gpio_oe[7]} : {uart_tx, 1'b1};
      e_p5 = (acm_driver_active || sel_mode_five == 2'h1) ? {uart_rts_n, 1'b1} :
         (sel_mode_five == 2'h3) ? {rs485_tx_en, 1'b1} : {gpio_out[5], gpio_oe[5]};
      e_p3 = sel_modem_two_three ? {uart_dtr_n, 1'b1} : {gpio_out[3], gpio_oe[3]};
      e_i2c = {!i2c_scl_drive_low, !i2c_sda_drive_low};
      e_fl[3] = acm_driver_active || sel_mode_five == 2'h1;
      e_fl[2] = e_fl[3] ? 1'b0 : gpio_oe[4];
      e_fl[1] = sel_modem_two_three;
      e_fl[0] = sel_modem_two_three ? 1'b0 : gpio_oe[2];
   endtask : step

   initial begin
      rnd = $urandom(32'h84bba94d);
      resetn <= 1'b0;
      for (int ph = 0; ph < 2; ph++) begin
         loaded = 1'b0;
         {l_lp, l_ven, l_hsp, l_sen} = {4{ph[0]}};
         {l_vid, l_pen, l_sch} = 29'($urandom());
         l_pid = 80'({$urandom(), $urandom(), $urandom()});
         l_mac = 48'({$urandom(), $urandom()});
         @(posedge core_clk);
         resetn <= 1'b0;
         drive_rand();
         repeat (5) @(posedge core_clk);
         resetn <= 1'b1;
         for (int i = 0; i < 40 && desc_ready !== 1'b1; i++) begin
            @(posedge core_clk);
            drive_rand();
            @(negedge core_clk);
         end
         `CHK("ready", 1'b1, desc_ready)
         loaded = 1'b1;
         step(1'b0);
         repeat (600) begin
            @(posedge core_clk);
            drive_rand();
            @(negedge core_clk);
            step(1'b1);
         end
      end
      summarize();
   end
endmodule : test_usb_compound_power_ident

// >>> dv/ucp_host_model.sv
`timescale 1ns/1ps
module ucp_host_model (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [2:0] host_cmd,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe,
   output logic usb_suspended,
   output logic usb_configured,
   output logic usb_high_speed,
   output wire scl_line,
   output wire sda_line
);
   // Board pull-ups on both lines
   assign scl_line = scl_oe ? scl_o : 1'b1;
   assign sda_line = sda_oe ? sda_o : 1'b1;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         {usb_high_speed, usb_suspended, usb_configured} <= 3'h0;
      end else begin
         {usb_high_speed, usb_suspended, usb_configured} <= host_cmd;
      end
   end
endmodule : ucp_host_model

// >>> dv/ucp_top_asserts.sv
`timescale 1ns/1ps
module ucp_top_asserts (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic otp_valid,
   input wire logic usb_suspended,
   input wire logic usb_configured,
   input wire logic board_self_powered,
   input wire logic [2:0] desc_func,
   input wire logic sel_gpio_seven,
   input wire logic uart_tx,
   input wire logic acm_driver_active,
   input wire logic uart_rts_n,
   input wire logic i2c_scl_drive_low,
   input wire logic i2c_sda_drive_low,
   input wire logic low_power_indicator,
   input wire logic desc_ready,
   input wire logic [1:0] desc_num_config,
   input wire logic eth_phy_power_down,
   input wire logic enhanced_io_seven_transmit_o,
   input wire logic enhanced_io_seven_transmit_oe,
   input wire logic enhanced_io_five_request_send_o,
   input wire logic enhanced_io_five_request_send_oe,
   input wire logic cts_to_uart_en,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_ready_held;
      desc_ready ##1 desc_ready;
   endsequence

   sequence s_active_unloaded;
      !desc_ready && !$past(otp_valid) && ($past(usb_suspended) || !$past(usb_configured));
   endsequence

   chk_ready_after_load: assert property ($rose(desc_ready) |-> $past(otp_valid, 2))
      else $error("ready without memory load");
   chk_ready_stays: assert property (desc_ready |-> s_ready_held)
      else $error("ready dropped");
   chk_lowpwr_default: assert property (s_active_unloaded |-> !low_power_indicator)
      else $error("indicator not active low");
   chk_phy_bus_down: assert property ($past(resetn) && $past(usb_suspended)
      && !$past(board_self_powered) |-> eth_phy_power_down)
      else $error("phy powered in bus powered suspend");
   chk_phy_awake: assert property ($past(resetn) && !$past(usb_suspended)
      |-> !eth_phy_power_down)
      else $error("phy down while awake");
   chk_tx_default: assert property ($past(resetn) && !$past(sel_gpio_seven)
      |-> enhanced_io_seven_transmit_oe && enhanced_io_seven_transmit_o == $past(uart_tx))
      else $error("pin seven not transmit");
   chk_acm_flow: assert property ($past(resetn) && $past(acm_driver_active)
      |-> enhanced_io_five_request_send_oe && cts_to_uart_en
      && enhanced_io_five_request_send_o == $past(uart_rts_n))
      else $error("flow pins not in flow role");
   chk_i2c_open_drain: assert property (!scl_o && !sda_o)
      else $error("i2c line driven high");
   chk_i2c_enable: assert property ($past(resetn) |-> scl_oe == $past(i2c_scl_drive_low)
      && sda_oe == $past(i2c_sda_drive_low))
      else $error("i2c enable mismatch");
   chk_one_config: assert property ($past(resetn) && $past(desc_func) < 3'h5
      |-> desc_num_config == 2'h1)
      else $error("configuration count wrong");
endmodule : ucp_top_asserts

bind ucp_top ucp_top_asserts i_chk (.*);

// >>> inc/ucp_pkg.sv
package ucp_pkg;

   // ------------------------------------------------------------
   // Functions behind the hub
   // ------------------------------------------------------------
   localparam int unsigned NUM_FUNC = 5;
   localparam logic [2:0] FN_HUB = 3'h0;
   localparam logic [2:0] FN_ETH = 3'h1;
   localparam logic [2:0] FN_UART = 3'h2;
   localparam logic [2:0] FN_I2C = 3'h3;
   localparam logic [2:0] FN_GPIO = 3'h4;

   // ------------------------------------------------------------
   // Identity defaults (arbitrary values)
   // ------------------------------------------------------------
   localparam logic [15:0] VID_DEFAULT = 16'h1234;
   localparam logic [15:0] PID_HUB_DEFAULT = 16'h0a01;
   localparam logic [15:0] PID_ETH_DEFAULT = 16'h0a02;
   localparam logic [15:0] PID_UART_DEFAULT = 16'h0a03;
   localparam logic [15:0] PID_I2C_DEFAULT = 16'h0a04;
   localparam logic [15:0] PID_GPIO_DEFAULT = 16'h0a05;

   // ------------------------------------------------------------
   // Power
   // ------------------------------------------------------------
   localparam logic [9:0] HUB_MAX_POWER_MA = 10'h0fa;
   localparam logic [7:0] HUB_MAX_POWER_DESC = 8'h7d;

   // ------------------------------------------------------------
   // Endpoint set bits: ctrl, int_in, int_out, bulk_in, bulk_out
   // ------------------------------------------------------------
   localparam int unsigned EP_CTRL = 0;
   localparam int unsigned EP_INT_IN = 1;
   localparam int unsigned EP_INT_OUT = 2;
   localparam int unsigned EP_BULK_IN = 3;
   localparam int unsigned EP_BULK_OUT = 4;
   localparam logic [4:0] EPS_HUB = 5'h03;
   localparam logic [4:0] EPS_BULK = 5'h1b;
   localparam logic [4:0] EPS_HID = 5'h07;
   localparam logic [1:0] NUM_CONFIG = 2'h1;

   // ------------------------------------------------------------
   // Pin modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      UCP_PM_GPIO = 2'h0,
      UCP_PM_UART = 2'h1,
      UCP_PM_RS485 = 2'h3
   } ucp_pin_mode_t;

   // Serial string: 12 hex chars of MAC, then one-time memory char if enabled, else function digit
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_A_MINUS_10 = 8'h37;

   // ------------------------------------------------------------
   // Bring-up sequence
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      UCP_ST_IDLE = 2'h0,
      UCP_ST_LOAD = 2'h1,
      UCP_ST_READY = 2'h3
   } ucp_state_t;

endpackage : ucp_pkg

// >>> verilog/ucp_top.sv
`timescale 1ns/1ps

module ucp_top (
   input wire logic core_clk,
   input wire logic resetn,
   // One-time memory contents and load handshake
   input wire logic otp_valid,
   input wire logic otp_lowpwr_active_high,
   input wire logic otp_vid_en,
   input wire logic [15:0] otp_vid,
   input wire logic [4:0] otp_pid_en,
   input wire logic [79:0] otp_pid,
   input wire logic otp_hub_self_powered,
   input wire logic otp_serial_en,
   input wire logic [7:0] otp_serial_char,
   input wire logic [47:0] mac_addr,
   // USB state
   input wire logic usb_suspended,
   input wire logic usb_configured,
   input wire logic usb_high_speed,
   input wire logic board_self_powered,
   // Descriptor query
   input wire logic [2:0] desc_func,
   input wire logic [3:0] desc_serial_idx,
   // UART, modem control, GPIO and I2C drive
   input wire logic acm_driver_active,
   input wire logic [1:0] sel_mode_five,
   input wire logic sel_gpio_seven,
   input wire logic sel_modem_two_three,
   input wire logic uart_tx,
   input wire logic uart_rts_n,
   input wire logic rs485_tx_en,
   input wire logic uart_dtr_n,
   input wire logic [7:0] gpio_out,
   input wire logic [7:0] gpio_oe,
   input wire logic i2c_scl_drive_low,
   input wire logic i2c_sda_drive_low,
   // Outputs
   output logic low_power_indicator,
   output logic desc_ready,
   output logic [15:0] desc_vid,
   output logic [15:0] desc_pid,
   output logic [7:0] desc_serial_char,
   output logic [4:0] desc_endpoints,
   output logic [1:0] desc_num_config,
   output logic desc_self_powered,
   output logic [7:0] desc_max_power,
   output logic desc_func_high_speed,
   output logic eth_phy_power_down,
   output logic enhanced_io_seven_transmit_o,
   output logic enhanced_io_seven_transmit_oe,
   output logic enhanced_io_five_request_send_o,
   output logic enhanced_io_five_request_send_oe,
   output logic enhanced_io_four_clear_send_oe,
   output logic enhanced_io_two_set_ready_oe,
   output logic enhanced_io_three_terminal_ready_o,
   output logic enhanced_io_three_terminal_ready_oe,
   output logic cts_to_uart_en,
   output logic dsr_to_uart_en,
   output logic scl_o,
   output logic scl_oe,
   output logic sda_o,
   output logic sda_oe
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      ucp_pkg::ucp_state_t st;
      logic lp_high;
      logic vid_en;
      logic [15:0] vid;
      logic [4:0] pid_en;
      logic [79:0] pid;
      logic hub_self;
      logic ser_en;
      logic [7:0] ser_char;
      logic [47:0] mac;
      logic lpi;
      logic rdy;
      logic [15:0] d_vid;
      logic [15:0] d_pid;
      logic [7:0] d_ser;
      logic [4:0] d_eps;
      logic [1:0] d_ncfg;
      logic d_self;
      logic [7:0] d_maxp;
      logic d_hs;
      logic phy_pd;
      logic [9:0] pins;
      logic cts_en;
      logic dsr_en;
      logic scl_oe;
      logic sda_oe;
   } ucp_state_t;

   ucp_state_t s_r;
   ucp_state_t s_nxt;

   // ------------------------------------------------------------
   // Per-function defaults
   // ------------------------------------------------------------
   logic [15:0] pid_def [ucp_pkg::NUM_FUNC];
   logic [4:0] eps_tab [ucp_pkg::NUM_FUNC];
   assign pid_def[0] = ucp_pkg::PID_HUB_DEFAULT;
   assign pid_def[1] = ucp_pkg::PID_ETH_DEFAULT;
   assign pid_def[2] = ucp_pkg::PID_UART_DEFAULT;
   assign pid_def[3] = ucp_pkg::PID_I2C_DEFAULT;
   assign pid_def[4] = ucp_pkg::PID_GPIO_DEFAULT;
   assign eps_tab[0] = ucp_pkg::EPS_HUB;
   assign eps_tab[1] = ucp_pkg::EPS_BULK;
   assign eps_tab[2] = ucp_pkg::EPS_BULK;
   assign eps_tab[3] = ucp_pkg::EPS_HID;
   assign eps_tab[4] = ucp_pkg::EPS_HID;

   logic [15:0] pid_sel [ucp_pkg::NUM_FUNC];
   genvar gi;
   generate
      for (gi = 0; gi < ucp_pkg::NUM_FUNC; gi++) begin : g_pid
         assign pid_sel[gi] = s_r.pid_en[gi] ? s_r.pid[gi*16 +: 16] : pid_def[gi];
      end
   endgenerate

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'ha) ? (ucp_pkg::ASCII_ZERO + {4'h0, n})
                            : (ucp_pkg::ASCII_A_MINUS_10 + {4'h0, n});
   endfunction : hex_char

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [2:0] f;
      logic valid_f;
      logic bus_pw;
      logic safe;
      f = desc_func;
      valid_f = (desc_func < 3'(ucp_pkg::NUM_FUNC));
      s_nxt = s_r;
      bus_pw = !(s_r.hub_self && board_self_powered);
      safe = usb_configured && !usb_suspended;
      unique case (s_r.st)
         ucp_pkg::UCP_ST_IDLE: begin
            s_nxt.st = ucp_pkg::UCP_ST_LOAD;
         end
         ucp_pkg::UCP_ST_LOAD: begin
            if (otp_valid) begin
               s_nxt.lp_high = otp_lowpwr_active_high;
               s_nxt.vid_en = otp_vid_en;
               s_nxt.vid = otp_vid;
               s_nxt.pid_en = otp_pid_en;
               s_nxt.pid = otp_pid;
               s_nxt.hub_self = otp_hub_self_powered;
               s_nxt.ser_en = otp_serial_en;
               s_nxt.ser_char = otp_serial_char;
               s_nxt.mac = mac_addr;
               s_nxt.st = ucp_pkg::UCP_ST_READY;
            end
         end
         ucp_pkg::UCP_ST_READY: begin
         end
         default: s_nxt.st = ucp_pkg::UCP_ST_IDLE;
      endcase
      s_nxt.rdy = (s_r.st == ucp_pkg::UCP_ST_READY);
      // Low-power indicator, active level from one-time memory
      s_nxt.lpi = safe ? !s_r.lp_high : s_r.lp_high;
      // Descriptor fields
      s_nxt.d_vid = s_r.vid_en ? s_r.vid : ucp_pkg::VID_DEFAULT;
      s_nxt.d_pid = valid_f ? pid_sel[f] : 16'h0000;
      s_nxt.d_eps = valid_f ? eps_tab[f] : 5'h00;
      s_nxt.d_ncfg = valid_f ? ucp_pkg::NUM_CONFIG : 2'h0;
      s_nxt.d_self = (f == ucp_pkg::FN_HUB) ? s_r.hub_self : 1'b1;
      s_nxt.d_maxp = (f == ucp_pkg::FN_HUB && !s_r.hub_self) ?
                     ucp_pkg::HUB_MAX_POWER_DESC : 8'h00;
      s_nxt.d_hs = (f != ucp_pkg::FN_HUB) || usb_high_speed;
      // Serial: 12 MAC hex chars then one-time memory char if enabled, else function digit 0..7
      if (desc_serial_idx < 4'hc) begin
         s_nxt.d_ser = hex_char(s_r.mac[6'(47 - 4 * desc_serial_idx) -: 4]);
      end else if (desc_serial_idx == 4'hc) begin
         s_nxt.d_ser = s_r.ser_en ? s_r.ser_char : (ucp_pkg::ASCII_ZERO + {5'h00, f});
      end else begin
         s_nxt.d_ser = 8'h00;
      end
      // Transceiver power-down in suspend unless self-powered both ways
      s_nxt.phy_pd = usb_suspended && bus_pw;
      // Pin seven
      s_nxt.pins[0] = sel_gpio_seven ? gpio_out[7] : uart_tx;
      s_nxt.pins[1] = sel_gpio_seven ? gpio_oe[7] : 1'b1;
      // Pin five
      unique case (acm_driver_active ? ucp_pkg::UCP_PM_UART
                                     : ucp_pkg::ucp_pin_mode_t'(sel_mode_five))
         ucp_pkg::UCP_PM_UART: begin
            s_nxt.pins[2] = uart_rts_n;
            s_nxt.pins[3] = 1'b1;
         end
         ucp_pkg::UCP_PM_RS485: begin
            s_nxt.pins[2] = rs485_tx_en;
            s_nxt.pins[3] = 1'b1;
         end
         default: begin
            s_nxt.pins[2] = gpio_out[5];
            s_nxt.pins[3] = gpio_oe[5];
         end
      endcase
      // Pin four: input for flow control, else GPIO
      s_nxt.cts_en = acm_driver_active || (sel_mode_five == ucp_pkg::UCP_PM_UART);
      s_nxt.pins[4] = s_nxt.cts_en ? 1'b0 : gpio_oe[4];
      // Pins two and three
      s_nxt.dsr_en = sel_modem_two_three;
      s_nxt.pins[5] = sel_modem_two_three ? 1'b0 : gpio_oe[2];
      s_nxt.pins[6] = sel_modem_two_three ? uart_dtr_n : gpio_out[3];
      s_nxt.pins[7] = sel_modem_two_three ? 1'b1 : gpio_oe[3];
      // Open drain: data level always low
      s_nxt.pins[9:8] = 2'h0;
      // I2C open drain: enable only to pull low
      s_nxt.scl_oe = i2c_scl_drive_low;
      s_nxt.sda_oe = i2c_sda_drive_low;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.lpi <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign low_power_indicator = s_r.lpi;
   assign desc_ready = s_r.rdy;
   assign desc_vid = s_r.d_vid;
   assign desc_pid = s_r.d_pid;
   assign desc_serial_char = s_r.d_ser;
   assign desc_endpoints = s_r.d_eps;
   assign desc_num_config = s_r.d_ncfg;
   assign desc_self_powered = s_r.d_self;
   assign desc_max_power = s_r.d_maxp;
   assign desc_func_high_speed = s_r.d_hs;
   assign eth_phy_power_down = s_r.phy_pd;
   assign enhanced_io_seven_transmit_o = s_r.pins[0];
   assign enhanced_io_seven_transmit_oe = s_r.pins[1];
   assign enhanced_io_five_request_send_o = s_r.pins[2];
   assign enhanced_io_five_request_send_oe = s_r.pins[3];
   assign enhanced_io_four_clear_send_oe = s_r.pins[4];
   assign enhanced_io_two_set_ready_oe = s_r.pins[5];
   assign enhanced_io_three_terminal_ready_o = s_r.pins[6];
   assign enhanced_io_three_terminal_ready_oe = s_r.pins[7];
   assign cts_to_uart_en = s_r.cts_en;
   assign dsr_to_uart_en = s_r.dsr_en;
   assign scl_o = s_r.pins[8];
   assign scl_oe = s_r.scl_oe;
   assign sda_o = s_r.pins[9];
   assign sda_oe = s_r.sda_oe;

endmodule : ucp_top
